// ---- bench/acs_conv_model.sv ----
// Front-end model: conversion codes for the selected calibration source
`timescale 1ns/1ps
`default_nettype none

module acs_conv_model #(
   parameter int SHORT_CODE = 32'h0000_1000,
   parameter int REF_CONV   = 32'h003D_0000
) (
   input  wire logic                              ref_clk_i,
   input  wire acs_pkg::acs_source_t              source_sel_i,
   input  wire logic                              cal_busy_i,
   input  wire logic signed [acs_pkg::DATA_W-1:0] analog_i,
   output var  logic signed [acs_pkg::DATA_W-1:0] conv_data_o
);
   import acs_pkg::*;

   logic signed [DATA_W-1:0] held;

   // ==========================================================================
   // Calibration voltage frozen while a step runs
   always_ff @(posedge ref_clk_i) begin
      if (!cal_busy_i) begin
         held <= analog_i;
      end
   end

   always_comb begin
      case (source_sel_i)
         SRC_SHORTED:   conv_data_o = DATA_W'(SHORT_CODE);
         SRC_REFERENCE: conv_data_o = DATA_W'(REF_CONV);
         default:       conv_data_o = held;
      endcase
   end
endmodule : acs_conv_model

`default_nettype wire

// ---- bench/test_adc_calibration_sequencer.sv ----
// Self-checking bench of the calibration sequencer
`timescale 1ns/1ps
`default_nettype none

module test_adc_calibration_sequencer;
   import acs_pkg::*;

   localparam int P     = 4;
   localparam int SHORT = 32'h0000_1000;
   localparam int REFC  = 32'h003D_0000;
   localparam int Z0    = 32'h0001_0000;
   localparam int Z1    = 32'h0002_0000;
   localparam int SPAN  = 32'h003D_0000;

   logic                     ref_clk_i   = 1'b0;
   logic                     rst_n_i     = 1'b0;
   acs_mode_cmd_t            cmd_i       = '0;
   logic                     bipolar_i   = 1'b0;
   logic                     word_read_i = 1'b0;
   logic signed [DATA_W-1:0] analog      = '0;
   logic signed [DATA_W-1:0] conv_data;
   logic signed [DATA_W-1:0] result;
   acs_source_t              src;
   acs_coef_t                coef;
   logic                     frst, rdy_n, valid, rerr, busy;
   logic [2:0]               mode;
   int                       n_fail   = 0;
   int                       compares = 0;
   int                       exp_off  = 0;
   int                       exp_gain = 0;
   int                       n;
   logic [31:0]              seed = 32'h0000_2FAB;
   int                       exp_q[$];

   always #25 ref_clk_i = ~ref_clk_i;

   acs_cal_seq #(.OUT_PERIOD(P)) dut (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i), .bipolar_i(bipolar_i),
      .conv_data_i(conv_data), .word_read_i(word_read_i), .source_sel_o(src),
      .filter_reset_o(frst), .result_ready_n_o(rdy_n), .result_o(result),
      .result_valid_o(valid), .coef_o(coef), .range_err_o(rerr), .cal_busy_o(busy),
      .cal_mode_o(mode));

   acs_conv_model #(.SHORT_CODE(SHORT), .REF_CONV(REFC)) front (
      .ref_clk_i(ref_clk_i), .source_sel_i(src), .cal_busy_i(busy),
      .analog_i(analog), .conv_data_o(conv_data));

   // ==========================================================================
   // Compare and bus tasks
   task automatic give_verdict();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict

   task automatic chk_code(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_code

   task automatic chk_word(input string nm, input logic signed [DATA_W-1:0] e);
      compares++;
      if (result !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, result);
      end
   endtask : chk_word

   task automatic chk_coef();
      acs_coef_t e;
      e.offset = COEF_W'(exp_off);
      e.gain   = COEF_W'(exp_gain);
      compares++;
      if (coef !== e) begin
         n_fail++;
         $display("MISMATCH coef expected %h seen %h", e, coef);
      end
   endtask : chk_coef

   task automatic wait_word(input int lo, input int hi);
      n = 0;
      do begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end while (rdy_n !== 1'b0 && n < 3000);
      compares++;
      if (n < lo || n > hi) begin
         n_fail++;
         $display("MISMATCH latency expected %0d..%0d seen %0d", lo, hi, n);
      end
   endtask : wait_word

   task automatic ack();
      @(posedge ref_clk_i);
      word_read_i <= 1'b1;
      @(posedge ref_clk_i);
      word_read_i <= 1'b0;
   endtask : ack

   task automatic issue(input logic [2:0] code);
      @(posedge ref_clk_i);
      cmd_i <= {1'b1, code};
      @(posedge ref_clk_i);
      cmd_i <= '0;
      // Ready looked at only once the command edge has passed
      #1;
      if (code inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5}) begin
         chk_code("filter_reset", 8'h01, {7'h00, frst});
         chk_code("ready_n_start", 8'h01, {7'h00, rdy_n});
      end
   endtask : issue

   // Whole calibration step; coef expectation set by the caller
   task automatic step(input logic [2:0] code, input int ana, input int periods);
      @(posedge ref_clk_i);
      analog <= DATA_W'(ana);
      issue(code);
      wait_word(periods * P - 2, periods * P + 4);
      chk_code("busy_done", 8'h00, {7'h00, busy});
      chk_coef();
      ack();
   endtask : step

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // ==========================================================================
   // Scenarios
   initial begin
      repeat (3) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      #1;
      chk_code("ready_n_reset", 8'h01, {7'h00, rdy_n});
      chk_code("mode_reset", {5'h00, MODE_RESET}, {5'h00, mode});
      chk_coef();
      exp_off = Z0;
      step(3'h2, Z0, 4);
      exp_gain = SPAN;
      step(3'h3, Z0 + SPAN, 4);
      exp_off = Z1;
      step(3'h2, Z1, 4);
      step(3'h3, Z1 + 32'h0010_0000, 4);
      chk_code("span_err", 8'h01, {7'h00, rerr});
      bipolar_i <= 1'b1;
      exp_gain = 32'h0040_0000;
      step(3'h3, Z1 + 32'h0020_0000, 4);
      chk_code("err_cleared", 8'h00, {7'h00, rerr});
      bipolar_i <= 1'b0;
      step(3'h2, 32'h0008_0000, 4);
      chk_code("fs_err", 8'h01, {7'h00, rerr});
      exp_off = SHORT;
      exp_gain = REFC - SHORT;
      step(3'h1, Z0, 9);
      exp_off = Z0;
      exp_gain = REFC - Z0;
      step(3'h4, Z0, 9);
      analog <= DATA_W'(Z1);
      issue(3'h5);
      exp_off = SHORT;
      exp_gain = REFC - SHORT;
      wait_word(6 * P - 4, 6 * P + 4);
      chk_code("bg_first_valid", 8'h00, {7'h00, valid});
      ack();
      wait_word(6 * P - 4, 6 * P + 4);
      chk_code("bg_second_valid", 8'h01, {7'h00, valid});
      chk_word("bg_word", DATA_W'(Z1 - SHORT));
      chk_coef();
      chk_code("bg_mode", {5'h00, MODE_BACKGROUND}, {5'h00, mode});
      ack();
      issue(3'h0);
      chk_code("normal_mode", {5'h00, MODE_NORMAL}, {5'h00, mode});
      repeat (6) begin
         seed = lfsr(seed);
         @(posedge ref_clk_i);
         analog <= DATA_W'(seed[19:0]);
         exp_q.push_back(int'(seed[19:0]) - exp_off);
         wait_word(1, P + 2);
         ack();
         wait_word(1, P + 2);
         chk_word("normal_word", DATA_W'(exp_q.pop_front()));
         ack();
      end
      give_verdict();
   end

   initial begin
      repeat (20000) @(posedge ref_clk_i);
      n_fail++;
      give_verdict();
   end
endmodule : test_adc_calibration_sequencer

`default_nettype wire

// ---- hw/acs_cal_seq.sv ----
// Calibration sequencer: mode decode, source selection, coefficient update, ready
`timescale 1ns/1ps
`default_nettype none

module acs_cal_seq #(
   parameter int OUT_PERIOD = acs_pkg::OUT_PERIOD_CYC,
   parameter int REF_CODE   = acs_pkg::REF_CODE_DEF
) (
   input  wire logic                              ref_clk_i,
   input  wire logic                              rst_n_i,
   input  wire acs_pkg::acs_mode_cmd_t            cmd_i,
   input  wire logic                              bipolar_i,
   input  wire logic signed [acs_pkg::DATA_W-1:0] conv_data_i,
   input  wire logic                              word_read_i,
   output var  acs_pkg::acs_source_t              source_sel_o,
   output var  logic                              filter_reset_o,
   output var  logic                              result_ready_n_o,
   output var  logic signed [acs_pkg::DATA_W-1:0] result_o,
   output var  logic                              result_valid_o,
   output var  acs_pkg::acs_coef_t                coef_o,
   output var  logic                              range_err_o,
   output var  logic                              cal_busy_o,
   output var  logic [2:0]                        cal_mode_o
);
   import acs_pkg::*;

   localparam logic signed [COEF_W-1:0] SPAN_MIN = COEF_W'(REF_CODE / 100 * SPAN_MIN_PCT);
   localparam logic signed [COEF_W-1:0] SPAN_MAX = COEF_W'(REF_CODE / 100 * SPAN_MAX_PCT);
   localparam logic signed [COEF_W-1:0] FS_MAX   = COEF_W'(REF_CODE / 100 * FS_MAX_PCT);

   // ==========================================================================
   // Range check shared by full-scale capture and offset-only steps
   function automatic logic range_ok(input logic signed [COEF_W-1:0] span,
                                     input logic signed [COEF_W-1:0] fs_point);
      range_ok = (span >= SPAN_MIN) && (span <= SPAN_MAX) && (fs_point <= FS_MAX);
   endfunction : range_ok

   // ==========================================================================
   // Command decode
   acs_state_t       state;
   acs_state_t       next_state;
   logic [CNT_W-1:0] period_cnt;
   logic [CNT_W-1:0] next_period_cnt;
   logic             two_step_done;
   logic             bg_first;
   logic             tick;

   wire [2:0] cmd_mode = {cmd_i.cal_mode_bit2, cmd_i.cal_mode_bit1, cmd_i.cal_mode_bit0};
   wire       cmd_cal  = (cmd_mode == MODE_SELF) || (cmd_mode == MODE_SYS_ZERO) ||
                         (cmd_mode == MODE_SYS_FULL) || (cmd_mode == MODE_SYS_OFF) ||
                         (cmd_mode == MODE_BACKGROUND);
   wire       cal_start = cmd_i.wr && cmd_cal;
   wire       cal_stop  = cmd_i.wr && !cmd_cal;

   acs_rate_div #(
      .PERIOD    (OUT_PERIOD)
   ) u_rate_div (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .restart_i (cal_start),
      .tick_o    (tick)
   );

   // ==========================================================================
   // Period events
   wire [CNT_W-1:0] ticked_cnt = period_cnt + 1'b1;
   wire is_self  = (state == CS_SELF);
   wire is_soff  = (state == CS_SYS_OFF);
   wire is_szero = (state == CS_SYS_ZERO);
   wire is_sfull = (state == CS_SYS_FULL);
   wire is_bg    = (state == CS_BG);
   wire live     = tick && !cmd_i.wr;

   wire zero_cap = live && (((is_self || is_soff) && ticked_cnt == SELF_ZERO_END) ||
                            (is_szero && ticked_cnt == SYS_CAPTURE_END) ||
                            (is_bg && ticked_cnt == BG_ZERO_END));
   wire full_cap = live && (((is_self || is_soff) && ticked_cnt == SELF_FULL_END) ||
                            (is_sfull && ticked_cnt == SYS_CAPTURE_END) ||
                            (is_bg && ticked_cnt == BG_FULL_END));
   wire step_done = live && (((is_self || is_soff) && ticked_cnt == SELF_DONE) ||
                             ((is_szero || is_sfull) && ticked_cnt == SYS_DONE));
   wire bg_frame  = live && is_bg && (ticked_cnt == BG_DONE);
   wire idle_word = live && (state == CS_IDLE);
   wire word_event = step_done || bg_frame || idle_word;
   wire sys_mode  = is_szero || is_sfull || is_soff;

   // ==========================================================================
   // Source selection
   acs_source_t next_source;
   always_comb begin
      next_source = SRC_ANALOG;
      if (is_self) begin
         if (period_cnt < SELF_ZERO_END) next_source = SRC_SHORTED;
         else if (period_cnt < SELF_FULL_END) next_source = SRC_REFERENCE;
      end else if (is_soff) begin
         if (period_cnt >= SELF_ZERO_END && period_cnt < SELF_FULL_END) next_source = SRC_REFERENCE;
      end else if (is_bg) begin
         if (period_cnt < BG_ZERO_END) next_source = SRC_SHORTED;
         else if (period_cnt < BG_FULL_END) next_source = SRC_REFERENCE;
      end
   end
   assign source_sel_o = next_source;

   // ==========================================================================
   // Coefficient arithmetic
   wire signed [COEF_W-1:0] conv_ext = COEF_W'(conv_data_i);
   wire signed [COEF_W-1:0] rise     = conv_ext - coef_o.offset;
   // Bipolar span is twice the midscale-to-positive-full-scale distance
   wire signed [COEF_W-1:0] new_span = bipolar_i ? COEF_W'(rise <<< 1) : rise;
   wire signed [COEF_W-1:0] reach    = bipolar_i ? (coef_o.gain >>> 1) : coef_o.gain;
   wire                     full_ok  = !sys_mode || range_ok(new_span, conv_ext);
   // An offset-only step after a full sequence must keep the full-scale point in range
   wire                     zero_ok  = !(is_szero && two_step_done) || range_ok(coef_o.gain, conv_ext + reach);
   wire signed [DATA_W-1:0] corrected = DATA_W'(rise);

   // ==========================================================================
   // Sequencer next state
   always_comb begin
      next_state      = state;
      next_period_cnt = period_cnt;
      if (cal_start) begin
         next_period_cnt = '0;
         case (cmd_mode)
            MODE_SELF:       next_state = CS_SELF;
            MODE_SYS_ZERO:   next_state = CS_SYS_ZERO;
            MODE_SYS_FULL:   next_state = CS_SYS_FULL;
            MODE_SYS_OFF:    next_state = CS_SYS_OFF;
            MODE_BACKGROUND: next_state = CS_BG;
            default:         next_state = CS_IDLE;
         endcase
      end else if (cal_stop) begin
         next_state      = CS_IDLE;
         next_period_cnt = '0;
      end else if (tick) begin
         case (state)
            CS_IDLE: next_period_cnt = '0;
            CS_BG:   next_period_cnt = bg_frame ? '0 : ticked_cnt;
            default: begin
               next_period_cnt = step_done ? '0 : ticked_cnt;
               if (step_done) next_state = CS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state      <= CS_IDLE;
         period_cnt <= '0;
         cal_mode_o <= MODE_RESET;
      end else begin
         state      <= next_state;
         period_cnt <= next_period_cnt;
         if (cmd_i.wr) cal_mode_o <= cmd_mode;
      end
   end

   // ==========================================================================
   // Coefficients and range flag
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         coef_o        <= '0;
         range_err_o   <= 1'b0;
         two_step_done <= 1'b0;
      end else begin
         if (zero_cap && zero_ok) coef_o.offset <= conv_ext;
         if (full_cap && full_ok) coef_o.gain <= new_span;
         // A failing capture wins over the clear of a new command
         if ((zero_cap && !zero_ok) || (full_cap && !full_ok)) range_err_o <= 1'b1;
         else if (cal_start) range_err_o <= 1'b0;
         if (full_cap && is_sfull && full_ok) two_step_done <= 1'b1;
         else if (cal_start && cmd_mode != MODE_SYS_ZERO && cmd_mode != MODE_SYS_FULL) two_step_done <= 1'b0;
      end
   end

   // ==========================================================================
   // Output word and ready
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         result_o         <= '0;
         result_valid_o   <= 1'b0;
         result_ready_n_o <= 1'b1;
         filter_reset_o   <= 1'b0;
         bg_first         <= 1'b0;
         cal_busy_o       <= 1'b0;
      end else begin
         filter_reset_o <= cal_start;
         cal_busy_o     <= (next_state != CS_IDLE) && (next_state != CS_BG);
         if (cal_start) begin
            result_ready_n_o <= 1'b1;
            result_valid_o   <= 1'b0;
            bg_first         <= (cmd_mode == MODE_BACKGROUND);
         end else if (word_event) begin
            result_o         <= corrected;
            result_valid_o   <= !(bg_frame && bg_first);
            result_ready_n_o <= 1'b0;
            if (bg_frame) bg_first <= 1'b0;
         end else if (word_read_i) begin
            result_ready_n_o <= 1'b1;
         end
      end
   end

   // ==========================================================================
   // Checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_start;
      cmd_i.wr && cmd_cal;
   endsequence

   sequence s_ready_low_idle;
      !result_ready_n_o && state == CS_IDLE;
   endsequence

   start_ready_high_a: assert property (s_start |=> result_ready_n_o && filter_reset_o)
      else $error("ready not raised or filter not reset on calibration start");
   filter_reset_pulse_a: assert property (filter_reset_o |-> $past(cal_start))
      else $error("filter reset without command");
   sys_step_done_a: assert property ((is_szero || is_sfull) && live && ticked_cnt == SYS_DONE
                                     |=> s_ready_low_idle)
      else $error("system step did not end with ready low");
   self_done_a: assert property ((is_self || is_soff) && live && ticked_cnt == SELF_DONE
                                 |=> s_ready_low_idle)
      else $error("one-step calibration did not end with ready low");
   busy_ready_a: assert property (cal_busy_o && !$past(cal_start) |-> result_ready_n_o)
      else $error("ready low during calibration step");
   slope_kept_a: assert property (is_szero && !cmd_i.wr |=> $stable(coef_o.gain))
      else $error("slope changed during zero-scale step");
   bg_hold_a: assert property (is_bg && !cmd_i.wr |=> is_bg)
      else $error("background mode left without a mode write");
   bg_rate_a: assert property (is_bg && word_event |-> ticked_cnt == BG_DONE)
      else $error("background word outside frame end");
   bg_arm_a: assert property (cal_start && cmd_mode == MODE_BACKGROUND |=> bg_first)
      else $error("background command did not mark the first frame");
   bg_first_a: assert property (is_bg && bg_frame && bg_first |=> !result_valid_o && !result_ready_n_o)
      else $error("first background result marked valid");
   sys_source_a: assert property (is_szero || is_sfull |-> source_sel_o == SRC_ANALOG)
      else $error("system step not converting the analog input");
   mode_reset_a: assert property (disable iff (1'b0) !rst_n_i |=> cal_mode_o == MODE_RESET)
      else $error("mode field not at default after reset");

endmodule : acs_cal_seq

`default_nettype wire

// ---- hw/acs_pkg.sv ----
// Shared constants, codes and carrier types of the calibration sequencer
package acs_pkg;

   // ==========================================================================
   // Widths
   localparam int DATA_W = 24;
   localparam int COEF_W = DATA_W + 2;
   localparam int CNT_W  = 4;

   // ==========================================================================
   // Mode field codes
   localparam logic [2:0] MODE_NORMAL     = 3'h0;
   localparam logic [2:0] MODE_SELF       = 3'h1;
   localparam logic [2:0] MODE_SYS_ZERO   = 3'h2;
   localparam logic [2:0] MODE_SYS_FULL   = 3'h3;
   localparam logic [2:0] MODE_SYS_OFF    = 3'h4;
   localparam logic [2:0] MODE_BACKGROUND = 3'h5;
   localparam logic [2:0] MODE_RESET      = MODE_NORMAL;

   // ==========================================================================
   // Sequence lengths in output periods, and capture points
   localparam logic [CNT_W-1:0] SELF_ZERO_END   = 4'h3;
   localparam logic [CNT_W-1:0] SELF_FULL_END   = 4'h6;
   localparam logic [CNT_W-1:0] SELF_DONE       = 4'h9;
   localparam logic [CNT_W-1:0] SYS_CAPTURE_END = 4'h3;
   localparam logic [CNT_W-1:0] SYS_DONE        = 4'h4;
   localparam logic [CNT_W-1:0] BG_ZERO_END     = 4'h1;
   localparam logic [CNT_W-1:0] BG_FULL_END     = 4'h2;
   localparam logic [CNT_W-1:0] BG_DONE         = 4'h6;

   // ==========================================================================
   // Timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int OUT_PERIOD_NS = 100000;
   localparam int OUT_PERIOD_CYC = (OUT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================================
   // Span and full-scale point limits, percent of reference over gain
   localparam int SPAN_MIN_PCT = 80;
   localparam int SPAN_MAX_PCT = 210;
   localparam int FS_MAX_PCT   = 105;
   localparam int REF_CODE_DEF = 4194304;

   // ==========================================================================
   // Types
   typedef enum logic [1:0] {SRC_ANALOG, SRC_SHORTED, SRC_REFERENCE} acs_source_t;

   typedef enum logic [2:0] {CS_IDLE, CS_SELF, CS_SYS_ZERO, CS_SYS_FULL, CS_SYS_OFF, CS_BG} acs_state_t;

   typedef struct packed {
      logic wr;
      logic cal_mode_bit2;
      logic cal_mode_bit1;
      logic cal_mode_bit0;
   } acs_mode_cmd_t;

   typedef struct packed {
      logic signed [COEF_W-1:0] offset;
      logic signed [COEF_W-1:0] gain;
   } acs_coef_t;

endpackage : acs_pkg

// ---- hw/acs_rate_div.sv ----
// Output update rate divider, restartable by a filter reset
`timescale 1ns/1ps
`default_nettype none

module acs_rate_div #(
   parameter int PERIOD = acs_pkg::OUT_PERIOD_CYC
) (
   input  wire logic ref_clk_i,
   input  wire logic rst_n_i,
   input  wire logic restart_i,
   output var  logic tick_o
);
   import acs_pkg::*;

   localparam int CW = $clog2(PERIOD + 1);
   localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   wire           at_last = (count == LAST);

   assign next_count = (restart_i || at_last) ? '0 : count + 1'b1;

   // ==========================================================================
   // Counter and registered tick
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         count  <= '0;
         tick_o <= 1'b0;
      end else begin
         count  <= next_count;
         tick_o <= at_last && !restart_i;
      end
   end

endmodule : acs_rate_div

`default_nettype wire
